// ==== shared/admc_pkg.sv ====
/*
  Constants for the audio DAC mode control register bank: register
  indexes, access word layout, field positions and reset values.
  Assumes nothing of its surroundings; every design file refers to
  these names as admc_pkg::name.
*/
package admc_pkg;

  // ****************************************************************
  // Access word layout
  // ****************************************************************
  localparam int unsigned WORD_RW_BIT = 15;    // 1 asks a read, 0 a write
  localparam int unsigned WORD_ADDR_HI = 14;   // Register index field
  localparam int unsigned WORD_ADDR_LO = 8;
  localparam int unsigned WORD_DATA_HI = 7;    // Data byte field
  localparam int unsigned WORD_DATA_LO = 0;

  // ****************************************************************
  // Register indexes
  // ****************************************************************
  localparam logic [6:0] IDX_LEFT_ATTEN = 7'h10;
  localparam logic [6:0] IDX_RIGHT_ATTEN = 7'h11;
  localparam logic [6:0] IDX_FMT_DEEMPH_MUTE = 7'h12;
  localparam logic [6:0] IDX_PHASE_SPEED_FILT = 7'h13;
  localparam logic [6:0] IDX_RESET_MODE_OS = 7'h14;
  localparam logic [6:0] IDX_ZERO_OUT = 7'h15;
  localparam logic [6:0] IDX_ZERO_FLAGS = 7'h16;
  localparam logic [6:0] IDX_DEVICE_IDENT = 7'h17;

  // ****************************************************************
  // Field positions (bit numbers inside the data byte)
  // ****************************************************************
  localparam int unsigned B_ATTEN_LOAD_GATE = 7;
  localparam int unsigned B_FORMAT_HI = 6;
  localparam int unsigned B_FORMAT_LO = 4;
  localparam int unsigned B_DEEMPH_RATE_HI = 3;
  localparam int unsigned B_DEEMPH_RATE_LO = 2;
  localparam int unsigned B_DEEMPH_ENABLE = 1;
  localparam int unsigned B_SOFT_MUTE = 0;
  localparam int unsigned B_PHASE_INVERT = 7;
  localparam int unsigned B_SPEED_HI = 6;
  localparam int unsigned B_SPEED_LO = 5;
  localparam int unsigned B_CONV_DISABLE = 4;
  localparam int unsigned B_BYPASS_STEREO = 2;
  localparam int unsigned B_ROLLOFF = 1;
  localparam int unsigned B_INF_ZERO_MUTE = 0;
  localparam int unsigned B_SYSTEM_RESET = 6;
  localparam int unsigned B_DSD_ENABLE = 5;
  localparam int unsigned B_FILTER_BYPASS = 4;
  localparam int unsigned B_MONO = 3;
  localparam int unsigned B_CHANNEL_SRC = 2;
  localparam int unsigned B_OS_HI = 1;
  localparam int unsigned B_OS_LO = 0;
  localparam int unsigned B_DSD_ZERO_HI = 2;
  localparam int unsigned B_DSD_ZERO_LO = 1;
  localparam int unsigned B_PCM_ZERO = 0;

  // ****************************************************************
  // Writable masks, reset values and special codes
  // ****************************************************************
  localparam logic [7:0] MASK_PHASE_SPEED_FILT = 8'hF7;
  localparam logic [7:0] MASK_RESET_MODE_OS = 8'h3F;
  localparam logic [7:0] MASK_ZERO_OUT = 8'h07;
  localparam logic [7:0] RST_ATTEN = 8'hFF;           // 0 dB
  localparam logic [7:0] RST_FMT_DEEMPH_MUTE = 8'h50; // 24-bit I2S
  localparam logic [7:0] RST_PHASE_SPEED_FILT = 8'h00;
  localparam logic [7:0] RST_RESET_MODE_OS = 8'h00;
  localparam logic [7:0] RST_ZERO_OUT = 8'h01;        // PCM zero out on
  localparam logic [7:0] ATTEN_MUTE_MAX = 8'h0E;      // Codes up to here mute
  localparam logic [2:0] FORMAT_RESERVED_LO = 3'h6;   // 110 and 111 reserved
  localparam logic [4:0] DEVICE_IDENT_DEFAULT = 5'h0A; // Arbitrary value

endpackage

// ==== rtl/admc_regs.sv ====
/*
  Mode control register bank of a stereo audio DAC. Holds the
  attenuation, format, de-emphasis, mute, filter, mode, oversampling
  and zero output controls, and answers reads of all eight registers.
  Assumes a serial control front end on the same clock that delivers
  each decoded 16-bit access word as a one-cycle strobe, and zero
  detect levels from the audio datapath on the same clock.
*/
// Overview of operation
// - Separate left and right 8-bit attenuation, default 0dB
// - Load gate bit in index 0x12, off at reset
// - Three-bit input format field, default 24-bit I2S
// - De-emphasis rate field plus enable, both default off
// - In DSD mode rate field selects FIR performance
// - Soft mute bit, default off, PCM mode only
// - Phase reversal bit honoured in every mode
// - Two-bit attenuation speed, default times one
// - Conversion disable bit, default conversion enabled
// - Bypass stereo select, bypass mode only, default mono
// - Rolloff select, PCM mode, default sharp
// - Infinite zero mute enable, PCM and bypass modes
// - System reset bit triggers a reset operation
// - DSD enable bit switches input path, default off
// - Filter bypass bit, default internal filter
// - Mono mode and channel source bits, all modes
// - Oversampling field, default times 64
// - In DSD mode oversampling field sets FIR rate
// - PCM zero output on, DSD zero output off
// - Read-only zero flags, one per channel
// - Read-only five-bit device identifier
// - All controls reset to defaults, all writable
// - Read bit one reads, zero writes
// - Gate low keeps previously applied attenuation
// - Format codes 110 and 111 are reserved
module admc_regs #(
  parameter logic [4:0] DEVICE_IDENT = admc_pkg::DEVICE_IDENT_DEFAULT // Arbitrary value
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic CLK_EN_I,
  input wire logic CMD_VALID_I,
  input wire logic [15:0] CMD_WORD_I,
  input wire logic LEFT_ZERO_DET_I,
  input wire logic RIGHT_ZERO_DET_I,
  output logic RD_VALID_O,
  output logic [7:0] RD_DATA_O,
  output logic [7:0] LEFT_ATTEN_LEVEL_O,
  output logic [7:0] RIGHT_ATTEN_LEVEL_O,
  output logic LEFT_ATTEN_MUTE_O,
  output logic RIGHT_ATTEN_MUTE_O,
  output logic [1:0] ATTEN_SPEED_SEL_O,
  output logic [2:0] INPUT_FORMAT_SEL_O,
  output logic DEEMPH_ACTIVE_O,
  output logic [1:0] DEEMPH_RATE_SEL_O,
  output logic [1:0] DSD_FIR_PERF_SEL_O,
  output logic SOFT_MUTE_O,
  output logic PHASE_INVERT_O,
  output logic CONVERSION_DISABLE_O,
  output logic BYPASS_STEREO_SEL_O,
  output logic ROLLOFF_SEL_O,
  output logic INFINITE_ZERO_MUTE_EN_O,
  output logic SYSTEM_RESET_PULSE_O,
  output logic DSD_MODE_O,
  output logic FILTER_BYPASS_O,
  output logic MONO_MODE_O,
  output logic SINGLE_CHANNEL_SOURCE_O,
  output logic [1:0] OVERSAMPLE_RATE_SEL_O,
  output logic [1:0] DSD_FIR_RATE_SEL_O,
  output logic PCM_ZERO_OUT_EN_O,
  output logic [1:0] DSD_ZERO_OUT_SEL_O
);

  // ****************************************************************
  // Access word decode
  // ****************************************************************
  logic [6:0] acc_idx;      // Register index of the access word
  logic [7:0] acc_data;     // Write data byte
  logic acc_rd;             // Read strobe this cycle
  logic acc_wr;             // Write strobe this cycle
  logic [7:0] left_atten_q;   // Written left attenuation code
  logic [7:0] right_atten_q;  // Written right attenuation code
  logic [7:0] left_applied_q;  // Attenuation the datapath uses
  logic [7:0] right_applied_q;
  logic [7:0] fmt_ctrl_q;   // Format, de-emphasis, mute, load gate
  logic [7:0] phase_ctrl_q; // Phase, speed, filter controls
  logic [7:0] mode_ctrl_q;  // Mode and oversampling controls
  logic [7:0] zero_ctrl_q;  // Zero output controls
  logic sys_reset_q;        // Reset operation pulse
  logic rd_valid_q;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic dsd_mode;           // Mode decode
  logic bypass_mode;
  logic pcm_mode;

  assign acc_idx = CMD_WORD_I[admc_pkg::WORD_ADDR_HI:admc_pkg::WORD_ADDR_LO];
  assign acc_data = CMD_WORD_I[admc_pkg::WORD_DATA_HI:admc_pkg::WORD_DATA_LO];
  // Direction bit picks read or write
  assign acc_rd = CLK_EN_I & CMD_VALID_I & CMD_WORD_I[admc_pkg::WORD_RW_BIT];
  assign acc_wr = CLK_EN_I & CMD_VALID_I & ~CMD_WORD_I[admc_pkg::WORD_RW_BIT];

  // ****************************************************************
  // Attenuation registers
  // ****************************************************************
  // Written codes always read back as written
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      left_atten_q <= admc_pkg::RST_ATTEN;
      right_atten_q <= admc_pkg::RST_ATTEN;
    end else if (acc_wr) begin
      if (acc_idx == admc_pkg::IDX_LEFT_ATTEN) begin
        left_atten_q <= acc_data;
      end else if (acc_idx == admc_pkg::IDX_RIGHT_ATTEN) begin
        right_atten_q <= acc_data;
      end
    end
  end

  // Applied levels follow a write only while the load gate is open;
  // the gate value before the write decides, so a gate write and an
  // attenuation write never race inside one access word
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      left_applied_q <= admc_pkg::RST_ATTEN;
      right_applied_q <= admc_pkg::RST_ATTEN;
    end else if (acc_wr && fmt_ctrl_q[admc_pkg::B_ATTEN_LOAD_GATE]) begin
      if (acc_idx == admc_pkg::IDX_LEFT_ATTEN) begin
        left_applied_q <= acc_data;
      end else if (acc_idx == admc_pkg::IDX_RIGHT_ATTEN) begin
        right_applied_q <= acc_data;
      end
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Format field refuses reserved codes so the audio port never sees one
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      fmt_ctrl_q <= admc_pkg::RST_FMT_DEEMPH_MUTE;
    end else if (acc_wr && acc_idx == admc_pkg::IDX_FMT_DEEMPH_MUTE) begin
      if (acc_data[admc_pkg::B_FORMAT_HI:admc_pkg::B_FORMAT_LO] >= admc_pkg::FORMAT_RESERVED_LO) begin
        // Keep old format, take the other fields
        fmt_ctrl_q <= {acc_data[admc_pkg::B_ATTEN_LOAD_GATE],
                       fmt_ctrl_q[admc_pkg::B_FORMAT_HI:admc_pkg::B_FORMAT_LO],
                       acc_data[admc_pkg::B_DEEMPH_RATE_HI:admc_pkg::B_SOFT_MUTE]};
      end else begin
        fmt_ctrl_q <= acc_data;
      end
    end
  end

  // Phase, speed, conversion, bypass stereo, rolloff, zero mute
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      phase_ctrl_q <= admc_pkg::RST_PHASE_SPEED_FILT;
    end else if (acc_wr && acc_idx == admc_pkg::IDX_PHASE_SPEED_FILT) begin
      phase_ctrl_q <= acc_data & admc_pkg::MASK_PHASE_SPEED_FILT;
    end
  end

  // Mode controls; the reset bit is not stored but fires a pulse
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mode_ctrl_q <= admc_pkg::RST_RESET_MODE_OS;
    end else if (acc_wr && acc_idx == admc_pkg::IDX_RESET_MODE_OS) begin
      mode_ctrl_q <= acc_data & admc_pkg::MASK_RESET_MODE_OS & ~(8'h01 << admc_pkg::B_SYSTEM_RESET);
    end
  end

  // One-cycle reset operation request to the datapath
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sys_reset_q <= 1'b0;
    end else if (CLK_EN_I) begin
      sys_reset_q <= acc_wr && acc_idx == admc_pkg::IDX_RESET_MODE_OS &&
                     acc_data[admc_pkg::B_SYSTEM_RESET];
    end
  end

  // Zero output controls
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      zero_ctrl_q <= admc_pkg::RST_ZERO_OUT;
    end else if (acc_wr && acc_idx == admc_pkg::IDX_ZERO_OUT) begin
      zero_ctrl_q <= acc_data & admc_pkg::MASK_ZERO_OUT;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Reserved bits and unmapped indexes read as zero; the read-only
  // registers have no write branch above, so writes to them vanish
  always_comb begin
    rd_data_d = 8'h00;
    if (acc_idx == admc_pkg::IDX_LEFT_ATTEN) begin
      rd_data_d = left_atten_q;
    end else if (acc_idx == admc_pkg::IDX_RIGHT_ATTEN) begin
      rd_data_d = right_atten_q;
    end else if (acc_idx == admc_pkg::IDX_FMT_DEEMPH_MUTE) begin
      rd_data_d = fmt_ctrl_q;
    end else if (acc_idx == admc_pkg::IDX_PHASE_SPEED_FILT) begin
      rd_data_d = phase_ctrl_q;
    end else if (acc_idx == admc_pkg::IDX_RESET_MODE_OS) begin
      rd_data_d = mode_ctrl_q;
    end else if (acc_idx == admc_pkg::IDX_ZERO_OUT) begin
      rd_data_d = zero_ctrl_q;
    end else if (acc_idx == admc_pkg::IDX_ZERO_FLAGS) begin
      rd_data_d = {6'h00, RIGHT_ZERO_DET_I, LEFT_ZERO_DET_I};
    end else if (acc_idx == admc_pkg::IDX_DEVICE_IDENT) begin
      rd_data_d = {3'h0, DEVICE_IDENT};
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else if (CLK_EN_I) begin
      rd_valid_q <= acc_rd;
      if (acc_rd) begin
        rd_data_q <= rd_data_d;
      end
    end
  end

  // ****************************************************************
  // Mode decode and effective controls
  // ****************************************************************
  // DSD wins over filter bypass; PCM is what remains
  assign dsd_mode = mode_ctrl_q[admc_pkg::B_DSD_ENABLE];
  assign bypass_mode = ~dsd_mode & mode_ctrl_q[admc_pkg::B_FILTER_BYPASS];
  assign pcm_mode = ~dsd_mode & ~bypass_mode;

  assign RD_VALID_O = rd_valid_q;
  assign RD_DATA_O = rd_data_q;
  assign LEFT_ATTEN_LEVEL_O = left_applied_q;
  assign RIGHT_ATTEN_LEVEL_O = right_applied_q;
  // In PCM mode, low codes mean full mute rather than a level
  assign LEFT_ATTEN_MUTE_O = pcm_mode & (left_applied_q <= admc_pkg::ATTEN_MUTE_MAX);
  assign RIGHT_ATTEN_MUTE_O = pcm_mode & (right_applied_q <= admc_pkg::ATTEN_MUTE_MAX);
  assign ATTEN_SPEED_SEL_O = phase_ctrl_q[admc_pkg::B_SPEED_HI:admc_pkg::B_SPEED_LO];
  assign INPUT_FORMAT_SEL_O = fmt_ctrl_q[admc_pkg::B_FORMAT_HI:admc_pkg::B_FORMAT_LO];
  assign DEEMPH_ACTIVE_O = pcm_mode & fmt_ctrl_q[admc_pkg::B_DEEMPH_ENABLE];
  assign DEEMPH_RATE_SEL_O = dsd_mode ? 2'h0 :
                             fmt_ctrl_q[admc_pkg::B_DEEMPH_RATE_HI:admc_pkg::B_DEEMPH_RATE_LO];
  // Same field, other meaning, in DSD mode
  assign DSD_FIR_PERF_SEL_O = dsd_mode ?
                              fmt_ctrl_q[admc_pkg::B_DEEMPH_RATE_HI:admc_pkg::B_DEEMPH_RATE_LO] : 2'h0;
  assign SOFT_MUTE_O = pcm_mode & fmt_ctrl_q[admc_pkg::B_SOFT_MUTE];
  assign PHASE_INVERT_O = phase_ctrl_q[admc_pkg::B_PHASE_INVERT];
  assign CONVERSION_DISABLE_O = phase_ctrl_q[admc_pkg::B_CONV_DISABLE];
  assign BYPASS_STEREO_SEL_O = bypass_mode & phase_ctrl_q[admc_pkg::B_BYPASS_STEREO];
  assign ROLLOFF_SEL_O = pcm_mode & phase_ctrl_q[admc_pkg::B_ROLLOFF];
  assign INFINITE_ZERO_MUTE_EN_O = ~dsd_mode & phase_ctrl_q[admc_pkg::B_INF_ZERO_MUTE];
  assign SYSTEM_RESET_PULSE_O = sys_reset_q;
  assign DSD_MODE_O = dsd_mode;
  assign FILTER_BYPASS_O = bypass_mode;
  assign MONO_MODE_O = mode_ctrl_q[admc_pkg::B_MONO];
  assign SINGLE_CHANNEL_SOURCE_O = mode_ctrl_q[admc_pkg::B_CHANNEL_SRC];
  assign OVERSAMPLE_RATE_SEL_O = dsd_mode ? 2'h0 : mode_ctrl_q[admc_pkg::B_OS_HI:admc_pkg::B_OS_LO];
  assign DSD_FIR_RATE_SEL_O = dsd_mode ? mode_ctrl_q[admc_pkg::B_OS_HI:admc_pkg::B_OS_LO] : 2'h0;
  assign PCM_ZERO_OUT_EN_O = ~dsd_mode & zero_ctrl_q[admc_pkg::B_PCM_ZERO];
  assign DSD_ZERO_OUT_SEL_O = dsd_mode ? zero_ctrl_q[admc_pkg::B_DSD_ZERO_HI:admc_pkg::B_DSD_ZERO_LO] : 2'h0;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_gate_closed_holds;
    @(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (acc_wr && !fmt_ctrl_q[7] && acc_idx == 7'h10) |=> $stable(LEFT_ATTEN_LEVEL_O);
  endproperty
  a_gate_closed_holds: assert property (p_gate_closed_holds) else $error("attenuation moved with gate closed");

  property p_gate_open_loads;
    @(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (acc_wr && fmt_ctrl_q[7] && acc_idx == 7'h11) |=> (RIGHT_ATTEN_LEVEL_O == $past(acc_data));
  endproperty
  a_gate_open_loads: assert property (p_gate_open_loads) else $error("attenuation not loaded with gate open");

  property p_read_answer;
    @(posedge REF_CLK_I) disable iff (!RESET_N_I)
    acc_rd |=> RD_VALID_O ##1 !RD_VALID_O || $past(acc_rd);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer missing");

  property p_ident_read;
    @(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (acc_rd && acc_idx == 7'h17) |=> (RD_DATA_O == {3'h0, DEVICE_IDENT});
  endproperty
  a_ident_read: assert property (p_ident_read) else $error("identifier read wrong");

  property p_flag_read;
    @(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (acc_rd && acc_idx == 7'h16) |=> (RD_DATA_O == {6'h00, $past(RIGHT_ZERO_DET_I), $past(LEFT_ZERO_DET_I)});
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("zero flags read wrong");

  property p_no_reserved_format;
    @(posedge REF_CLK_I) disable iff (!RESET_N_I)
    1'b1 |-> (INPUT_FORMAT_SEL_O < 3'h6);
  endproperty
  a_no_reserved_format: assert property (p_no_reserved_format) else $error("reserved format applied");

  property p_reset_pulse;
    @(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (acc_wr && acc_idx == 7'h14 && CMD_WORD_I[6]) |=> SYSTEM_RESET_PULSE_O ##1 (!SYSTEM_RESET_PULSE_O || !CLK_EN_I
      || $past(acc_wr));
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("system reset pulse wrong");

  property p_ro_write_ignored;
    @(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (acc_wr && acc_idx >= 7'h16) |=> ($stable(fmt_ctrl_q) && $stable(mode_ctrl_q) && $stable(zero_ctrl_q));
  endproperty
  a_ro_write_ignored: assert property (p_ro_write_ignored) else $error("read-only write disturbed state");

  property p_dsd_fir_reuse;
    @(posedge REF_CLK_I) disable iff (!RESET_N_I)
    DSD_MODE_O |-> (DSD_FIR_PERF_SEL_O == fmt_ctrl_q[3:2] && DSD_FIR_RATE_SEL_O == mode_ctrl_q[1:0]
      && !SOFT_MUTE_O);
  endproperty
  a_dsd_fir_reuse: assert property (p_dsd_fir_reuse) else $error("DSD reuse of fields wrong");

  // Applied levels never move without an attenuation write, so
  // opening the gate later does not pull in a stored code
  property p_applied_hold;
    @(posedge REF_CLK_I) disable iff (!RESET_N_I)
    !acc_wr |=> ($stable(LEFT_ATTEN_LEVEL_O) && $stable(RIGHT_ATTEN_LEVEL_O));
  endproperty
  a_applied_hold: assert property (p_applied_hold) else $error("level moved without write");

  // A low clock enable freezes the stored controls even under a strobe
  property p_enable_freeze;
    @(posedge REF_CLK_I) disable iff (!RESET_N_I)
    !CLK_EN_I |=> ($stable(phase_ctrl_q) && $stable(mode_ctrl_q) && $stable(zero_ctrl_q) && $stable(left_atten_q));
  endproperty
  a_enable_freeze: assert property (p_enable_freeze) else $error("state moved with enable low");

  // DSD wins, so the bypass flag drops while DSD is on
  property p_one_mode;
    @(posedge REF_CLK_I) disable iff (!RESET_N_I)
    DSD_MODE_O |-> !FILTER_BYPASS_O;
  endproperty
  a_one_mode: assert property (p_one_mode) else $error("two modes signalled");

  // Clearing the PCM zero output bit turns the enable off next cycle
  property p_zero_out_off;
    @(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (acc_wr && acc_idx == admc_pkg::IDX_ZERO_OUT && !acc_data[admc_pkg::B_PCM_ZERO]) |=> !PCM_ZERO_OUT_EN_O;
  endproperty
  a_zero_out_off: assert property (p_zero_out_off) else $error("zero output stayed on");

  // A mode write without the reset bit must not fire the pulse
  property p_no_stray_pulse;
    @(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (acc_wr && acc_idx == admc_pkg::IDX_RESET_MODE_OS && !acc_data[admc_pkg::B_SYSTEM_RESET])
      |=> !SYSTEM_RESET_PULSE_O;
  endproperty
  a_no_stray_pulse: assert property (p_no_stray_pulse) else $error("reset pulse without its bit");

  // The reset bit is never stored, so it always reads back as zero
  property p_reset_bit_reads_zero;
    @(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (acc_rd && acc_idx == admc_pkg::IDX_RESET_MODE_OS) |=> !RD_DATA_O[admc_pkg::B_SYSTEM_RESET];
  endproperty
  a_reset_bit_reads_zero: assert property (p_reset_bit_reads_zero) else $error("reset bit read back");

endmodule

// ==== sim/admc_host_model.sv ====
/*
  Host controller model for the mode control register bank: turns
  register accesses into single-cycle access word strobes.
  Assumes the bank takes a word at the edge where the strobe is high
  and answers a read exactly one cycle later.
*/
module admc_host_model (
  input wire logic clk_i,
  input wire logic rd_valid_i,
  input wire logic [7:0] rd_data_i,
  output logic cmd_valid_o,
  output logic [15:0] cmd_word_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Access sequencing
  // ****************************************************************
  initial begin
    cmd_valid_o = 1'b0;
    cmd_word_o = 16'h0000;
  end

  // One access: strobe for one edge, then release the word inverted so
  // a stale value can never pass for a fresh one
  task automatic access(input logic rd, input logic [6:0] idx, input logic [7:0] data,
                        output logic valid, output logic [7:0] rdata);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_word_o <= {rd, idx, data};
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_word_o <= ~{rd, idx, data};
    // A write has landed and a read answer stands from this edge to the
    // next one, so both are looked at here once settled
    #1;
    valid = rd_valid_i;
    rdata = rd_data_i;
  endtask
endmodule

// ==== sim/audio_dac_mode_control_regs_test.sv ====
/*
  Self-checking testbench for the mode control register bank.
  Assumes the host model drives access words and the bench drives
  reset and the zero-detect levels, all on one 100 MHz clock.
*/
module audio_dac_mode_control_regs_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk = 1'b0, reset_n = 1'b0, zl = 1'b0, zr = 1'b0, clk_en = 1'b1; // Inputs driven by the bench
  logic cmd_valid, rd_valid, l_mute, r_mute, de_act, s_mute, ph_inv, conv_dis, byp_st, roll, inz;
  logic sys_rst, dsd, f_byp, mono, chsrc, pcm_z;
  logic [15:0] cmd_word;
  logic [7:0] rd_data, l_lvl, r_lvl;
  logic [2:0] fmt;
  logic [1:0] speed, de_rate, fir_perf, os_sel, fir_rate, dsd_z;
  int fail_count = 0, checked = 0;

  always #5 clk = ~clk; // 100 MHz

  admc_host_model host (.clk_i(clk), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
    .cmd_valid_o(cmd_valid), .cmd_word_o(cmd_word));

  // Identity parameter set to an arbitrary value
  admc_regs #(.DEVICE_IDENT(5'h15)) dut (.REF_CLK_I(clk), .RESET_N_I(reset_n), .CLK_EN_I(clk_en),
    .CMD_VALID_I(cmd_valid), .CMD_WORD_I(cmd_word), .LEFT_ZERO_DET_I(zl), .RIGHT_ZERO_DET_I(zr),
    .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data), .LEFT_ATTEN_LEVEL_O(l_lvl), .RIGHT_ATTEN_LEVEL_O(r_lvl),
    .LEFT_ATTEN_MUTE_O(l_mute), .RIGHT_ATTEN_MUTE_O(r_mute), .ATTEN_SPEED_SEL_O(speed),
    .INPUT_FORMAT_SEL_O(fmt), .DEEMPH_ACTIVE_O(de_act), .DEEMPH_RATE_SEL_O(de_rate),
    .DSD_FIR_PERF_SEL_O(fir_perf), .SOFT_MUTE_O(s_mute), .PHASE_INVERT_O(ph_inv),
    .CONVERSION_DISABLE_O(conv_dis), .BYPASS_STEREO_SEL_O(byp_st), .ROLLOFF_SEL_O(roll),
    .INFINITE_ZERO_MUTE_EN_O(inz), .SYSTEM_RESET_PULSE_O(sys_rst), .DSD_MODE_O(dsd),
    .FILTER_BYPASS_O(f_byp), .MONO_MODE_O(mono), .SINGLE_CHANNEL_SOURCE_O(chsrc),
    .OVERSAMPLE_RATE_SEL_O(os_sel), .DSD_FIR_RATE_SEL_O(fir_rate), .PCM_ZERO_OUT_EN_O(pcm_z),
    .DSD_ZERO_OUT_SEL_O(dsd_z));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] idx, input logic [7:0] data);
    logic v;
    logic [7:0] d;
    host.access(1'b0, idx, data, v, d);
  endtask

  // Read and compare both the answer strobe and the byte
  task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
    logic v;
    logic [7:0] d;
    host.access(1'b1, idx, 8'h00, v, d);
    check(8'(v), 8'h01, "read strobe");
    check(d, exp, "read data");
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Defaults of every register and the format and PCM zero outputs after reset
  task automatic t_reset_values();
    zr <= 1'b1;
    rd(7'h10, 8'hFF);
    rd(7'h11, 8'hFF);
    rd(7'h12, 8'h50);
    rd(7'h13, 8'h00);
    rd(7'h14, 8'h00);
    rd(7'h15, 8'h01);
    rd(7'h16, 8'h02);
    rd(7'h17, 8'h15);
    check(8'(fmt), 8'h05, "format default");
    check(8'(pcm_z), 8'h01, "pcm zero default");
    $display("test reset values done");
  endtask

  // Gate closed keeps the applied level; gate open loads it, low codes mute
  task automatic t_atten_gate();
    wr(7'h10, 8'h40);
    check(l_lvl, 8'hFF, "gated level");
    rd(7'h10, 8'h40);
    wr(7'h12, 8'h80);
    wr(7'h11, 8'h0E);
    check(r_lvl, 8'h0E, "loaded level");
    check(8'(r_mute), 8'h01, "code 14 mutes");
    wr(7'h11, 8'h0F);
    check(8'(r_mute), 8'h00, "code 15 plays");
    wr(7'h10, 8'h00);
    check(8'(l_mute), 8'h01, "code 0 mutes");
    $display("test attenuation gate done");
  endtask

  // Format, de-emphasis and soft mute; a reserved format is refused
  task automatic t_format();
    wr(7'h12, 8'hB3);
    check(8'(fmt), 8'h03, "format");
    check(8'({de_act, s_mute}), 8'h03, "deemph and mute");
    wr(7'h12, 8'hE8);
    check(8'(fmt), 8'h03, "reserved format");
    check(8'({de_rate, s_mute}), 8'h04, "rate and mute");
    $display("test format done");
  endtask

  // Phase, speed, conversion, rolloff and zero mute controls
  task automatic t_phase_filter();
    wr(7'h13, 8'hF7);
    rd(7'h13, 8'hF7);
    check(8'({ph_inv, speed, conv_dis, roll, inz}), 8'h3F, "control bits");
    check(8'(byp_st), 8'h00, "stereo outside bypass");
    // A write offered while the clock enable is low must not land
    @(posedge clk);
    clk_en <= 1'b0;
    wr(7'h13, 8'h00);
    check(8'(ph_inv), 8'h01, "frozen by enable");
    @(posedge clk);
    clk_en <= 1'b1;
    $display("test phase and filter done");
  endtask

  // Reset pulse, DSD reinterpretation, bypass mode, read-only and unmapped places
  task automatic t_modes();
    wr(7'h14, 8'h40);
    check(8'(sys_rst), 8'h01, "reset pulse");
    @(posedge clk);
    #1;
    check(8'(sys_rst), 8'h00, "reset pulse end");
    rd(7'h14, 8'h00);
    wr(7'h15, 8'h06);
    wr(7'h14, 8'h2F);
    check(8'({dsd, mono, chsrc, os_sel, fir_rate}), 8'h73, "dsd mode");
    check(8'({fir_perf, de_rate, dsd_z, pcm_z}), 8'h46, "dsd fields");
    wr(7'h14, 8'h11);
    check(8'({dsd, f_byp, byp_st, os_sel}), 8'h0D, "bypass mode");
    wr(7'h16, 8'hFF);
    wr(7'h17, 8'hFF);
    @(posedge clk);
    zl <= 1'b1;
    zr <= 1'b0;
    rd(7'h16, 8'h01);
    rd(7'h17, 8'h15);
    rd(7'h15, 8'h06);
    rd(7'h20, 8'h00);
    $display("test modes done");
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_reset_values();
    t_atten_gate();
    t_format();
    t_phase_filter();
    t_modes();
    summarize();
  end

  // The whole run takes under a hundred cycles; this leaves ample margin
  initial begin
    #50000;
    fail_count++;
    summarize();
  end
endmodule
